// >>> verilog/fsc_defines.vh
// Register offsets, field positions, reset values and timing counts for the floppy status/control bank
`ifndef FSC_DEFINES_VH
`define FSC_DEFINES_VH
`define FSC_ADDR_STATUS_A 10'h3f0
`define FSC_ADDR_STATUS_B 10'h3f1
`define FSC_ADDR_DRIVE_OUTPUT 10'h3f2
`define FSC_ADDR_TAPE_ASSIGN 10'h3f3
`define FSC_ADDR_DIGITAL_INPUT 10'h3f7
`define FSC_DOC_RESET 8'h00
`define FSC_TAPE_RESET 2'h0
`define FSC_DOC_SEL_LO 0
`define FSC_DOC_SEL_HI 1
`define FSC_DOC_SOFT_RST 2
`define FSC_DOC_DMA_EN 3
`define FSC_DOC_MOTOR0 4
`define FSC_MODE_AT 2'h0
`define FSC_MODE_ENH 2'h1
`define FSC_MODE_M30 2'h2
`define FSC_SOFT_RST_MIN_NS 100
`define FSC_CLK_PERIOD_NS 10
// Minimum soft reset rounded up to whole clock periods, sized for the stretch counter
`define FSC_SOFT_RST_CYCLES 4'ha
`endif

// >>> verilog/fsc_sync.v
// Two-flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
`default_nettype none
module fsc_sync #(
  parameter WIDTH = 1
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_r;
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_r <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/fsc_edge_latch.v
// Sticky flag set by a qualifying edge, cleared by a pulse; set wins over clear
`timescale 1ns/100ps
`default_nettype none
module fsc_edge_latch (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_sig,
  input wire i_rise,
  input wire i_clear,
  output reg o_flag
);
  reg prev_r;
  wire hit;
  assign hit = i_rise ? (i_sig & ~prev_r) : (~i_sig & prev_r);
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev_r <= 1'b0;
      o_flag <= 1'b0;
    end else begin
      prev_r <= i_sig;
      if (hit)
        o_flag <= 1'b1;
      else if (i_clear)
        o_flag <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/fsc_regs.v
// Floppy controller status and control register bank with single-drive decode
//
// Behaviour
// - Model-30 status A bit 0 is direction inverted: 1 means stepping outward.
// - Model-30 status A bits 1, 2, 4 show write-protect, index, track-zero active high.
// - Model-30 status A bit 3 is head side inverted: 1 means side 0.
// - Model-30 status A bit 5 latches step; cleared by input read or resets.
// - Model-30 status A bit 6 shows DMA request, bit 7 shows interrupt.
// - Status B readable in enhanced mode; bus undriven on read in AT mode.
// - Enhanced status B bit 0 mirrors motor 0; hardware reset only clears it.
// - Enhanced status B bit 1 reads 0, bits 6 and 7 read 1.
// - Enhanced status B bit 2 shows write gate; bits 3, 4 toggle on data edges.
// - Enhanced status B bit 5 mirrors drive select bit 0 of control register.
// - Model-30 status B bits 0, 1, 6 read 1; bit 7 unsupported drive type.
// - Model-30 status B bit 2 latches write gate rising; input read clears.
// - Model-30 status B bits 3, 4 latch data falling edges; input read clears.
// - Model-30 status B bit 5 shows drive select 0 output active low.
// - Output control register writable anytime; zeroed by hardware reset only.
// - Bit 2 low holds controller in soft reset, at least 100 ns.
// - Bit 3 gates DMA and interrupt in AT and Model-30; always on in enhanced.
// - Drive select 0 low when select bits 00 and motor bit set; motor low inverts bit 4.
// - Tape select bits 1:0 kept at 00 by software; soft reset leaves them.
// - Tape register read returns zeros in bits 7:2.
// - Status A undriven on read in AT mode; readable otherwise.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_defines.vh"
module fsc_regs (
  input wire i_clk,
  input wire i_reset_n,
  input wire [1:0] i_mode,
  input wire [9:0] i_io_addr,
  input wire i_io_rd,
  input wire i_io_wr,
  input wire [7:0] i_io_wdata,
  output reg [7:0] o_io_rdata,
  output reg o_io_rdata_oe,
  input wire i_step,
  input wire i_dir_out,
  input wire i_head_side_select,
  input wire i_write_gate_out,
  input wire i_wdata_out,
  input wire i_dma_req,
  input wire i_irq,
  input wire i_rdata_in,
  input wire i_wp_in,
  input wire i_index_in,
  input wire i_track_zero_in,
  output reg o_drive_select0_out_low,
  output reg o_motor0_out_low,
  output reg o_ctl_soft_reset_low,
  output reg o_dma_irq_enable,
  output reg [1:0] o_tape_sel
);
  reg [7:0] drive_output_control_reg_r;
  reg [1:0] tape_drive_assign_reg_r;
  reg rd_toggle_r;
  reg wr_toggle_r;
  reg rd_prev_r;
  reg wr_prev_r;
  reg [3:0] soft_cnt_r;
  reg [7:0] status_a_reg;
  reg [7:0] status_b_reg;
  reg [7:0] rdata_nxt;
  reg oe_nxt;
  wire [2:0] pin_s;
  wire step_ff;
  wire wg_ff;
  wire rd_ff;
  wire wd_ff;
  wire dir_rd;
  wire soft_active;
  wire wr_doc;
  wire mode_enh;
  wire mode_at;
  wire drive0_sel;
  assign mode_enh = (i_mode == `FSC_MODE_ENH);
  assign mode_at = (i_mode == `FSC_MODE_AT);
  assign dir_rd = i_io_rd & (i_io_addr == `FSC_ADDR_DIGITAL_INPUT);
  assign wr_doc = i_io_wr & (i_io_addr == `FSC_ADDR_DRIVE_OUTPUT);
  assign soft_active = ~drive_output_control_reg_r[`FSC_DOC_SOFT_RST] | (soft_cnt_r != 4'h0);
  assign drive0_sel = (drive_output_control_reg_r[1:0] == 2'h0) & drive_output_control_reg_r[`FSC_DOC_MOTOR0];

  fsc_sync #(
    .WIDTH(3)
  ) u_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async({i_wp_in, i_index_in, i_track_zero_in}),
    .o_sync(pin_s)
  );

  // Read data arrives from the drive, so it is synchronised on its own
  wire rdata_s;
  fsc_sync #(
    .WIDTH(1)
  ) u_sync_rd (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_rdata_in),
    .o_sync(rdata_s)
  );

  fsc_edge_latch u_step (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_sig(i_step),
    .i_rise(1'b1),
    .i_clear(dir_rd | soft_active),
    .o_flag(step_ff)
  );
  fsc_edge_latch u_write_gate_out (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_sig(i_write_gate_out),
    .i_rise(1'b1),
    .i_clear(dir_rd),
    .o_flag(wg_ff)
  );
  fsc_edge_latch u_rdata (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_sig(rdata_s),
    .i_rise(1'b0),
    .i_clear(dir_rd),
    .o_flag(rd_ff)
  );
  fsc_edge_latch u_wdata (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_sig(i_wdata_out),
    .i_rise(1'b0),
    .i_clear(dir_rd),
    .o_flag(wd_ff)
  );

  // Control register and tape select survive the self-held soft reset
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      drive_output_control_reg_r <= `FSC_DOC_RESET;
      tape_drive_assign_reg_r <= `FSC_TAPE_RESET;
      soft_cnt_r <= 4'h0;
    end else begin
      if (wr_doc)
        drive_output_control_reg_r <= i_io_wdata;
      if (i_io_wr && (i_io_addr == `FSC_ADDR_TAPE_ASSIGN))
        tape_drive_assign_reg_r <= i_io_wdata[1:0];
      // Stretch a short low pulse on the reset bit to the minimum duration
      if (wr_doc && !i_io_wdata[`FSC_DOC_SOFT_RST])
        soft_cnt_r <= `FSC_SOFT_RST_CYCLES;
      else if (soft_cnt_r != 4'h0)
        soft_cnt_r <= soft_cnt_r - 4'h1;
    end
  end

  // Toggle bits follow data trailing edges and are not touched by soft reset
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
      rd_toggle_r <= 1'b0;
      wr_toggle_r <= 1'b0;
    end else begin
      rd_prev_r <= rdata_s;
      wr_prev_r <= i_wdata_out;
      if (rd_prev_r && !rdata_s)
        rd_toggle_r <= ~rd_toggle_r;
      if (wr_prev_r && !i_wdata_out)
        wr_toggle_r <= ~wr_toggle_r;
    end
  end

  always @* begin
    status_a_reg = {i_irq, i_dma_req, step_ff, pin_s[0], ~i_head_side_select, pin_s[1], pin_s[2], ~i_dir_out};
    if (mode_enh) begin
      status_b_reg = {2'b11, drive_output_control_reg_r[`FSC_DOC_SEL_LO], wr_toggle_r, rd_toggle_r,
                      i_write_gate_out, 1'b0, drive_output_control_reg_r[`FSC_DOC_MOTOR0]};
    end else begin
      status_b_reg = {2'b11, ~drive0_sel, wd_ff, rd_ff, wg_ff, 2'b11};
    end
    rdata_nxt = 8'h00;
    oe_nxt = 1'b0;
    if (i_io_rd) begin
      case (i_io_addr)
        `FSC_ADDR_STATUS_A: begin
          rdata_nxt = status_a_reg;
          oe_nxt = ~mode_at;
        end
        `FSC_ADDR_STATUS_B: begin
          rdata_nxt = status_b_reg;
          oe_nxt = ~mode_at;
        end
        `FSC_ADDR_DRIVE_OUTPUT: begin
          rdata_nxt = drive_output_control_reg_r;
          oe_nxt = 1'b1;
        end
        `FSC_ADDR_TAPE_ASSIGN: begin
          rdata_nxt = {6'h00, tape_drive_assign_reg_r};
          oe_nxt = 1'b1;
        end
        default: begin
          rdata_nxt = 8'h00;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_io_rdata <= 8'h00;
      o_io_rdata_oe <= 1'b0;
      o_drive_select0_out_low <= 1'b1;
      o_motor0_out_low <= 1'b1;
      o_ctl_soft_reset_low <= 1'b0;
      o_dma_irq_enable <= 1'b0;
      o_tape_sel <= 2'h0;
    end else begin
      o_io_rdata <= rdata_nxt;
      o_io_rdata_oe <= oe_nxt;
      o_drive_select0_out_low <= ~drive0_sel;
      o_motor0_out_low <= ~drive_output_control_reg_r[`FSC_DOC_MOTOR0];
      o_ctl_soft_reset_low <= ~soft_active;
      o_dma_irq_enable <= mode_enh | drive_output_control_reg_r[`FSC_DOC_DMA_EN];
      o_tape_sel <= tape_drive_assign_reg_r;
    end
  end
endmodule
`default_nettype wire

// >>> bench/fsc_regs_properties.sv
// Port checks for the floppy status and control bank
`timescale 1ns/100ps
`default_nettype none
module fsc_regs_properties (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [1:0] i_mode,
  input wire logic [9:0] i_io_addr,
  input wire logic i_io_rd,
  input wire logic i_io_wr,
  input wire logic [7:0] i_io_wdata,
  input wire logic [7:0] o_io_rdata,
  input wire logic o_io_rdata_oe,
  input wire logic i_dir_out,
  input wire logic i_head_side_select,
  input wire logic o_drive_select0_out_low,
  input wire logic o_motor0_out_low,
  input wire logic o_ctl_soft_reset_low,
  input wire logic [1:0] o_tape_sel
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Lone write to the control register
  sequence doc_wr_s;
    i_io_wr && i_io_addr == 10'h3f2 ##1 !i_io_wr;
  endsequence
  AST_DS0: assert property (doc_wr_s |=>
    o_drive_select0_out_low == (($past(i_io_wdata, 2) & 8'h13) != 8'h10)) else $error("drive select decode");
  AST_MOTOR: assert property (doc_wr_s |=> o_motor0_out_low == !$past(i_io_wdata[4], 2))
    else $error("motor decode");
  AST_AT_HIZ: assert property (i_mode == 2'h0 && i_io_rd && i_io_addr[9:1] == 9'h1f8 |=> !o_io_rdata_oe)
    else $error("status driven in compatible mode");
  AST_RD_IDLE: assert property (!i_io_rd |=> !o_io_rdata_oe) else $error("bus driven without read");
  AST_SRB_ENH: assert property (i_mode == 2'h1 && i_io_rd && i_io_addr == 10'h3f1 |=> o_io_rdata_oe &&
    o_io_rdata[7:6] == 2'h3 && !o_io_rdata[1] && o_io_rdata[0] == !o_motor0_out_low) else $error("status b");
  AST_TAPE: assert property (i_io_rd && i_io_addr == 10'h3f3 |=> o_io_rdata_oe &&
    o_io_rdata == {6'h0, o_tape_sel}) else $error("tape read");
  AST_SOFT_MIN: assert property ($fell(o_ctl_soft_reset_low) |-> !o_ctl_soft_reset_low [*8])
    else $error("soft reset too short");
  AST_SRA_M30: assert property (i_mode == 2'h2 && i_io_rd && i_io_addr == 10'h3f0 |=>
    o_io_rdata[0] == !$past(i_dir_out) && o_io_rdata[3] == !$past(i_head_side_select)) else $error("status a");
endmodule
bind fsc_regs fsc_regs_properties i_fsc_regs_properties (.i_clk, .i_reset_n, .i_mode, .i_io_addr, .i_io_rd,
  .i_io_wr, .i_io_wdata, .o_io_rdata, .o_io_rdata_oe, .i_dir_out, .i_head_side_select,
  .o_drive_select0_out_low, .o_motor0_out_low, .o_ctl_soft_reset_low, .o_tape_sel);
`default_nettype wire

// >>> bench/fsc_drive_model.sv
// Single drive: sense lines answer only while selected
`timescale 1ns/100ps
`default_nettype none
module fsc_drive_model (
  input wire logic i_sel_low,
  input wire logic [3:0] i_want,
  output logic [3:0] o_pins
);
  // Deselected drive holds every line at 0, which leaves each sense inactive
  assign o_pins = i_sel_low ? 4'h0 : i_want;
endmodule
`default_nettype wire

// >>> bench/fsc_regs_bench.sv
// Self-checking bench for the floppy status and control bank
`timescale 1ns/100ps
`default_nettype none
module fsc_regs_bench;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, dir = 0, head = 0, wg = 0, wd = 0, step = 0, dreq = 0, irq = 0;
  logic [1:0] mode = 2'h1;
  logic [9:0] addr = 10'h0;
  logic [7:0] wdata = 8'h0;
  logic [3:0] want = 4'h0;
  wire [3:0] pins;
  wire [7:0] rdata;
  wire oe, ds0l, motl, softl, dma_irq_enable;
  wire [1:0] tape;
  int n_mismatch = 0, compares = 0;
  // Control byte, then expected drive select low and motor low
  logic [9:0] rows [5] = '{10'h070, 10'h060, 10'h076, 10'h07a, 10'h033};
  always #5 clk = ~clk;
  fsc_regs i_fsc_regs (.i_clk(clk), .i_reset_n(rst_n), .i_mode(mode), .i_io_addr(addr), .i_io_rd(rd),
    .i_io_wr(wr), .i_io_wdata(wdata), .o_io_rdata(rdata), .o_io_rdata_oe(oe), .i_step(step), .i_dir_out(dir),
    .i_head_side_select(head), .i_write_gate_out(wg), .i_wdata_out(wd), .i_dma_req(dreq), .i_irq(irq),
    .i_rdata_in(pins[0]), .i_wp_in(pins[1]), .i_index_in(pins[2]), .i_track_zero_in(pins[3]),
    .o_drive_select0_out_low(ds0l), .o_motor0_out_low(motl), .o_ctl_soft_reset_low(softl),
    .o_dma_irq_enable(dma_irq_enable), .o_tape_sel(tape));
  fsc_drive_model i_fsc_drive_model (.i_sel_low(ds0l), .i_want(want), .o_pins(pins));
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrt(logic [9:0] a, logic [7:0] d);
    @(negedge clk) {wr, addr, wdata} = {1'b1, a, d};
    @(negedge clk) wr = 0;
  endtask
  task automatic rdc(logic [9:0] a, logic [7:0] exp, logic exp_oe);
    @(negedge clk) {rd, addr} = {1'b1, a};
    @(negedge clk) rd = 0;
    chk("oe", {7'h0, exp_oe}, {7'h0, oe});
    if (exp_oe) chk("rdata", exp, rdata);
  endtask
  task automatic rst(logic [1:0] m);
    @(negedge clk) {rst_n, mode} = {1'b0, m};
    repeat (4) @(negedge clk);
    rst_n = 1;
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    rst(2'h1);
    chk("reset pins", 8'h0c, {3'h0, softl, ds0l, motl, tape});
    rdc(10'h3f2, 8'h00, 1'b1);
    foreach (rows[i]) begin
      wrt(10'h3f2, rows[i][9:2]);
      @(negedge clk);
      chk("drive", {6'h0, rows[i][1:0]}, {6'h0, ds0l, motl});
      rdc(10'h3f2, rows[i][9:2], 1'b1);
      rdc(10'h3f1, {2'h3, rows[i][2], 4'h0, rows[i][6]}, 1'b1);
    end
    wrt(10'h3f2, 8'h18);
    wrt(10'h3f2, 8'h1c);
    chk("soft low", 8'h0, {7'h0, softl});
    for (int k = 0; k < 30 && !softl; k++) @(negedge clk);
    chk("soft high", 8'h1, {7'h0, softl});
    rdc(10'h3f2, 8'h1c, 1'b1);
    wrt(10'h3f3, 8'hfc);
    rdc(10'h3f3, 8'h00, 1'b1);
    rdc(10'h3f6, 8'h00, 1'b0);
    $display("enhanced tests done");
    rst(2'h0);
    rdc(10'h3f0, 8'h00, 1'b0);
    rdc(10'h3f1, 8'h00, 1'b0);
    wrt(10'h3f2, 8'h0c);
    @(negedge clk);
    chk("dma enable", 8'h1, {7'h0, dma_irq_enable});
    $display("compatible tests done");
    rst(2'h2);
    wrt(10'h3f2, 8'h1c);
    {dir, head, want} = {2'h3, 4'he};
    repeat (5) @(negedge clk);
    rdc(10'h3f0, 8'h16, 1'b1);
    rdc(10'h3f1, 8'hc3, 1'b1);
    {step, dreq, irq} = 3'h7;
    @(negedge clk);
    rdc(10'h3f0, 8'hf6, 1'b1);
    @(negedge clk) {wg, wd, want} = {2'h3, 4'hf};
    @(negedge clk) {wg, wd, want} = {2'h0, 4'he};
    repeat (5) @(negedge clk);
    rdc(10'h3f1, 8'hdf, 1'b1);
    rdc(10'h3f7, 8'h00, 1'b0);
    rdc(10'h3f1, 8'hc3, 1'b1);
    {dreq, irq} = 2'h0;
    rdc(10'h3f0, 8'h16, 1'b1);
    $display("model 30 tests done");
    report_and_stop();
  end
endmodule
`default_nettype wire
